// File: rtl/udn_top.sv
// udn_top: request routing and smartcard nack/retransmit control.
// assumes the uart core, dma and interrupt controller run on ref_clk.
// Operation
// - route 0, tx empty enable and flag set: raise tx interrupt request
// - route 1, tx empty enable and flag set: raise tx dma request instead
// - tx empty enable clear: no tx dma nor interrupt request
// - reserved route bits 6,4,3..0 and smartcard bits 7..5 read zero
// - rx full enable clear: no rx dma nor interrupt request
// - rx full enable and flag set: irq or dma per rx route bit 5
// - smartcard control ignored while smartcard mode is off
// - overrun nack enable sends nack on overrunning character
// - overrun nack enable clear: no nack for overflow
// - automatic nacks only under protocol t=0
// - overrun and error nack enables act independently
// - error nack on parity error or invalid initial character
// - error nack enable: retransmit nacked data without limit
// - protocol type 0 selects t=0, 1 selects t=1
// - init detect searches every received character; the code searches only under t=0
// - mode enable switches ordinary and smartcard operation
`timescale 1ns/1ps
`default_nettype none
module udn_top #(
	parameter int RETRY_W = 8
) (
	// clock, reset, enable
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	input  wire logic                 ce,
	// register port
	input  wire logic [7:0]           regAddr,
	input  wire logic [7:0]           regWdata,
	input  wire logic                 regWr,
	input  wire logic                 regRd,
	output logic      [7:0]           regRdata,
	// uart core flags
	input  wire logic                 txEmptyFlag,
	input  wire logic                 rxFullFlag,
	input  wire logic                 txCompleteFlag,
	// receive and transmit events
	input  wire udn_pkg::udn_rx_evt_t rxEvt,
	input  wire logic                 txNackSeen,
	input  wire logic                 txCharEnd,
	// requests
	output udn_pkg::udn_req_t         txReq,
	output udn_pkg::udn_req_t         rxReq,
	output logic                      txCompleteIrq,
	// smartcard line control
	output logic                      nackSend,
	output logic                      txRetransmit,
	output logic                      rxDiscard,
	output logic                      txEnable,
	output logic                      scMode
);
	import udn_pkg::*;

	logic [7:0]         ctlReg;
	logic [7:0]         ctlNext;
	logic [7:0]         drcReg;
	logic [7:0]         drcNext;
	logic [7:0]         sccReg;
	logic [7:0]         sccNext;
	logic [7:0]         rdReg;
	logic [7:0]         rdNext;
	udn_rt_st_t         rtReg;
	udn_rt_st_t         rtNext;
	logic [RETRY_W-1:0] cntReg;
	logic [RETRY_W-1:0] cntNext;
	udn_sc_cfg_t        scCfg;
	logic               initHit;
	logic               retryOk;
	logic               scT0;

	// only the low five bits of smartcard control exist
	assign scCfg = sccReg[4:0];
	assign scT0  = scCfg.modeEn & (scCfg.proto == PROTO_T0);

	// register writes; masks keep reserved bits at zero
	always_comb begin
		ctlNext = ctlReg;
		drcNext = drcReg;
		sccNext = sccReg;
		// hardware clears init detect on a valid initial character
		if (initHit)
			sccNext[SCC_INIT] = 1'b0;
		if (regWr) begin
			if (regAddr == OFS_CTRL)
				ctlNext = regWdata & CTL_MASK;
			else if (regAddr == OFS_DMARC)
				drcNext = regWdata & DRC_MASK;
			else if (regAddr == OFS_SCC)
				sccNext = regWdata & SCC_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ctlReg <= CTL_RST;
			drcReg <= DRC_RST;
			sccReg <= SCC_RST;
		end else if (ce) begin
			ctlReg <= ctlNext;
			drcReg <= drcNext;
			sccReg <= sccNext;
		end
	end

	// read data stand only in the cycle after the strobe
	always_comb begin
		rdNext = 8'h00;
		if (regRd) begin
			if (regAddr == OFS_CTRL)
				rdNext = ctlReg;
			else if (regAddr == OFS_STAT) begin
				rdNext[STA_TDE] = txEmptyFlag;
				rdNext[STA_TXC] = txCompleteFlag;
				rdNext[STA_RDF] = rxFullFlag;
				rdNext[STA_RT]  = (rtReg != RT_IDLE);
			end else if (regAddr == OFS_DMARC)
				rdNext = drcReg & DRC_MASK;
			else if (regAddr == OFS_SCC)
				rdNext = sccReg & SCC_MASK;
			else if (regAddr == OFS_RETRY)
				rdNext = 8'(cntReg);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst)
			rdReg <= 8'h00;
		else if (ce)
			rdReg <= rdNext;
	end

	assign regRdata = rdReg;

	// request steering, one instance per flag
	udn_req_route u_txRoute (
		.en   (ctlReg[CTL_TXE_IEN]),
		.flag (txEmptyFlag),
		.sel  (drcReg[DRC_TXSEL]),
		.req  (txReq)
	);

	udn_req_route u_rxRoute (
		.en   (ctlReg[CTL_RXF_IEN]),
		.flag (rxFullFlag),
		.sel  (drcReg[DRC_RXSEL]),
		.req  (rxReq)
	);

	// transmit complete has no dma route
	assign txCompleteIrq = ctlReg[CTL_TXC_IEN] & txCompleteFlag;

	// nack decision per received character
	udn_nack_gen u_nack (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.ce       (ce),
		.cfg      (scCfg),
		.evt      (rxEvt),
		.nackSend (nackSend),
		.initHit  (initHit)
	);

	// receiver throws data away until a valid initial character
	assign rxDiscard = scT0 & scCfg.init;
	assign txEnable  = ctlReg[CTL_TX_EN];
	assign scMode    = scCfg.modeEn;

	// retries run only while tx enable, mode, t=0 and error nack hold;
	// clearing any of the four or the card's accept on txCharEnd ends them, there is no limit
	assign retryOk = scT0 & scCfg.errNack & ctlReg[CTL_TX_EN];

	// retransmit sequencer
	always_comb begin
		rtNext  = rtReg;
		cntNext = cntReg;
		case (rtReg)
			RT_IDLE: begin
				if (retryOk && txNackSeen) begin
					rtNext  = RT_SEND;
					cntNext = '0;
				end
			end
			RT_SEND: begin
				rtNext = RT_WAIT;
				// count saturates for display only, retries go on
				if (cntReg != '1)
					cntNext = cntReg + 1'b1;
			end
			RT_WAIT: begin
				if (!retryOk)
					rtNext = RT_IDLE;
				else if (txNackSeen)
					rtNext = RT_SEND;
				else if (txCharEnd)
					rtNext = RT_IDLE;
			end
			default: rtNext = RT_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rtReg  <= RT_IDLE;
			cntReg <= '0;
		end else if (ce) begin
			rtReg  <= rtNext;
			cntReg <= cntNext;
		end
	end

	// one pulse per resend, from the state register
	assign txRetransmit = (rtReg == RT_SEND);

	property p_tx_irq;
		@(posedge ref_clk) disable iff (!nrst)
		ctlReg[CTL_TXE_IEN] && txEmptyFlag && !drcReg[DRC_TXSEL]
		|-> txReq.irq && !txReq.dma;
	endproperty
	a_tx_irq: assert property (p_tx_irq)
		else $error("tx empty did not raise irq");

	property p_tx_dma;
		@(posedge ref_clk) disable iff (!nrst)
		ctlReg[CTL_TXE_IEN] && txEmptyFlag && drcReg[DRC_TXSEL]
		|-> txReq.dma && !txReq.irq;
	endproperty
	a_tx_dma: assert property (p_tx_dma)
		else $error("tx empty did not raise dma");

	property p_tx_off;
		@(posedge ref_clk) disable iff (!nrst)
		!ctlReg[CTL_TXE_IEN] |-> !txReq.irq && !txReq.dma;
	endproperty
	a_tx_off: assert property (p_tx_off)
		else $error("tx request with tie clear");

	property p_rx_off;
		@(posedge ref_clk) disable iff (!nrst)
		!ctlReg[CTL_RXF_IEN] |-> !rxReq.irq && !rxReq.dma;
	endproperty
	a_rx_off: assert property (p_rx_off)
		else $error("rx request with rie clear");

	property p_rx_on;
		@(posedge ref_clk) disable iff (!nrst)
		ctlReg[CTL_RXF_IEN] && rxFullFlag
		|-> rxReq.dma == drcReg[DRC_RXSEL]
		&& rxReq.irq == !drcReg[DRC_RXSEL];
	endproperty
	a_rx_on: assert property (p_rx_on)
		else $error("rx full routed wrongly");

	property p_level;
		@(posedge ref_clk) disable iff (!nrst)
		$fell(txEmptyFlag) |-> !txReq.irq && !txReq.dma;
	endproperty
	a_level: assert property (p_level)
		else $error("tx request outlived its flag");

	property p_rsv;
		@(posedge ref_clk) disable iff (!nrst)
		ce && regRd && (regAddr == OFS_DMARC || regAddr == OFS_SCC)
		|=> (regRdata & ~(DRC_MASK | SCC_MASK)) == 8'h00
		&& ($past(regAddr) != OFS_DMARC || regRdata[6] == 1'b0)
		&& ($past(regAddr) != OFS_SCC || regRdata[7:5] == 3'h0);
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved bit read as one");

	property p_retry;
		@(posedge ref_clk) disable iff (!nrst)
		ce && retryOk && txNackSeen && rtReg != RT_SEND
		|=> txRetransmit ##1 !txRetransmit;
	endproperty
	a_retry: assert property (p_retry)
		else $error("nacked data not resent");

	property p_mode_off;
		@(posedge ref_clk) disable iff (!nrst)
		!scCfg.modeEn |-> !rxDiscard && !scMode;
	endproperty
	a_mode_off: assert property (p_mode_off)
		else $error("smartcard effect with mode off");

	property p_init_clr;
		@(posedge ref_clk) disable iff (!nrst)
		ce && initHit && !regWr |=> !scCfg.init && !rxDiscard;
	endproperty
	a_init_clr: assert property (p_init_clr)
		else $error("init detect not cleared");

	property p_t1_init;
		@(posedge ref_clk) disable iff (!nrst)
		scCfg.proto == PROTO_T1 |-> !rxDiscard && !txRetransmit;
	endproperty
	a_t1_init: assert property (p_t1_init)
		else $error("t=0 behaviour under t=1");

	property p_off_retry;
		@(posedge ref_clk) disable iff (!nrst)
		ce && !scCfg.modeEn && rtReg == RT_WAIT |=> rtReg == RT_IDLE;
	endproperty
	a_off_retry: assert property (p_off_retry)
		else $error("retry kept with mode off");

endmodule : udn_top
`default_nettype wire

// File: rtl/udn_pkg.sv
// udn_pkg: offsets, field positions, reset values and carriers for the
// uart request routing and smartcard nack block.
// assumes an 8-bit register port and one 25 MHz clock domain.
package udn_pkg;

	// clock period in ns, kept for reference by timing users
	localparam int CLK_PERIOD_NS = 40;

	// register offsets
	localparam logic [7:0] OFS_CTRL  = 8'h03;
	localparam logic [7:0] OFS_STAT  = 8'h04;
	localparam logic [7:0] OFS_DMARC = 8'h0b;
	localparam logic [7:0] OFS_SCC   = 8'h18;
	localparam logic [7:0] OFS_RETRY = 8'h1a;

	// dma_route_control fields
	localparam int         DRC_TXSEL = 7;
	localparam int         DRC_RXSEL = 5;
	localparam logic [7:0] DRC_MASK  = 8'ha0;
	localparam logic [7:0] DRC_RST   = 8'h00;

	// smartcard_control fields
	localparam int         SCC_OVRNK = 4;
	localparam int         SCC_ERRNK = 3;
	localparam int         SCC_INIT  = 2;
	localparam int         SCC_PROTO = 1;
	localparam int         SCC_MODE  = 0;
	localparam logic [7:0] SCC_MASK  = 8'h1f;
	localparam logic [7:0] SCC_RST   = 8'h00;

	// control register fields
	localparam int         CTL_TXE_IEN = 7;
	localparam int         CTL_TXC_IEN = 6;
	localparam int         CTL_RXF_IEN = 5;
	localparam int         CTL_TX_EN   = 3;
	localparam logic [7:0] CTL_MASK    = 8'he8;
	localparam logic [7:0] CTL_RST     = 8'h00;

	// status register fields
	localparam int STA_TDE = 7;
	localparam int STA_TXC = 6;
	localparam int STA_RDF = 5;
	localparam int STA_RT  = 4;

	// protocol type codes
	localparam logic PROTO_T0 = 1'b0;
	localparam logic PROTO_T1 = 1'b1;

	// receive character events from the receiver core
	typedef struct packed {
		logic done;
		logic parityErr;
		logic overrun;
		logic initValid;
		logic initInvalid;
	} udn_rx_evt_t;

	// mirrors smartcard_control bits 4..0
	typedef struct packed {
		logic ovrNack;
		logic errNack;
		logic init;
		logic proto;
		logic modeEn;
	} udn_sc_cfg_t;

	// one request pair
	typedef struct packed {
		logic irq;
		logic dma;
	} udn_req_t;

	// retransmit sequencer
	typedef enum logic [1:0] {RT_IDLE, RT_SEND, RT_WAIT} udn_rt_st_t;

endpackage : udn_pkg

// File: rtl/udn_req_route.sv
// udn_req_route: steers one flag onto an interrupt or a dma request.
// assumes flag and controls come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module udn_req_route (
	// controls
	input  wire logic           en,
	input  wire logic           flag,
	input  wire logic           sel,
	// request pair
	output udn_pkg::udn_req_t   req
);
	import udn_pkg::*;

	// level requests, held while enable and flag hold
	always_comb begin
		req.irq = en & flag & ~sel;
		req.dma = en & flag & sel;
	end

endmodule : udn_req_route
`default_nettype wire

// File: rtl/udn_nack_gen.sv
// udn_nack_gen: decides an automatic nack per received character.
// assumes rx events are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module udn_nack_gen (
	// clock and control
	input  wire logic                ref_clk,
	input  wire logic                nrst,
	input  wire logic                ce,
	// configuration and events
	input  wire udn_pkg::udn_sc_cfg_t cfg,
	input  wire udn_pkg::udn_rx_evt_t evt,
	// results
	output logic                     nackSend,
	output logic                     initHit
);
	import udn_pkg::*;

	logic active;
	logic nackNext;
	logic nackReg;

	// nack only in smartcard mode under t=0
	always_comb begin
		active   = cfg.modeEn & (cfg.proto == PROTO_T0);
		nackNext = 1'b0;
		if (active && evt.done) begin
			if (cfg.ovrNack && evt.overrun)
				nackNext = 1'b1;
			if (cfg.errNack && evt.parityErr)
				nackNext = 1'b1;
			if (cfg.errNack && cfg.init && evt.initInvalid)
				nackNext = 1'b1;
		end
		// every character is searched while init detect is on in t=0 smartcard mode
		initHit = active & cfg.init & evt.done & evt.initValid;
	end

	// registered so the line driver sees a clean pulse
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			nackReg <= 1'b0;
		else if (ce)
			nackReg <= nackNext;
	end

	assign nackSend = nackReg;

	property p_ovr_nack;
		@(posedge ref_clk) disable iff (!nrst)
		ce && cfg.modeEn && cfg.proto == PROTO_T0 && cfg.ovrNack
		&& evt.done && evt.overrun |=> nackSend;
	endproperty
	a_ovr_nack: assert property (p_ovr_nack)
		else $error("overrun did not nack");

	property p_no_ovr_nack;
		@(posedge ref_clk) disable iff (!nrst)
		ce && !cfg.ovrNack && evt.overrun && !evt.parityErr
		&& !evt.initInvalid |=> !nackSend;
	endproperty
	a_no_ovr_nack: assert property (p_no_ovr_nack)
		else $error("nack on overrun while disabled");

	property p_t1_quiet;
		@(posedge ref_clk) disable iff (!nrst)
		ce && cfg.proto == PROTO_T1 |=> !nackSend;
	endproperty
	a_t1_quiet: assert property (p_t1_quiet)
		else $error("nack under t=1");

	property p_err_nack;
		@(posedge ref_clk) disable iff (!nrst)
		ce && cfg.modeEn && cfg.proto == PROTO_T0 && cfg.errNack
		&& evt.done && (evt.parityErr || (cfg.init && evt.initInvalid))
		|=> nackSend;
	endproperty
	a_err_nack: assert property (p_err_nack)
		else $error("error did not nack");

	property p_indep;
		@(posedge ref_clk) disable iff (!nrst)
		ce && cfg.modeEn && cfg.proto == PROTO_T0 && !cfg.errNack
		&& cfg.ovrNack && evt.done && evt.overrun ##1 1 |-> nackSend;
	endproperty
	a_indep: assert property (p_indep)
		else $error("overrun nack needs error nack");

	property p_off_quiet;
		@(posedge ref_clk) disable iff (!nrst)
		ce && !cfg.modeEn |=> !nackSend;
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("nack outside smartcard mode");

endmodule : udn_nack_gen
`default_nettype wire

// File: sim/udn_card_model.sv
// udn_card_model: smartcard seen from the block's serial side.
// assumes one ref_clk domain; each sent character is answered later.
`timescale 1ns/1ps
`default_nettype none
module udn_card_model (
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	// bench commands
	input  wire logic                 charGo,
	input  wire udn_pkg::udn_rx_evt_t charEvt,
	input  wire logic                 startTx,
	input  wire logic [7:0]           nackCount,
	input  wire logic                 slow,
	// block side
	input  wire logic                 txRetransmit,
	output udn_pkg::udn_rx_evt_t      rxEvt,
	output logic                      txNackSeen,
	output logic                      txCharEnd
);
	import udn_pkg::*;
	int         waitCnt;
	logic [7:0] left;
	// a slow card gives software time to abort before the next reject
	always @(posedge ref_clk) begin
		rxEvt <= charGo ? charEvt : '0;
		txNackSeen <= 1'b0;
		txCharEnd <= 1'b0;
		if (!nrst) begin
			waitCnt <= 0;
		end else if (startTx || txRetransmit) begin
			if (startTx) begin
				left <= nackCount;
			end
			waitCnt <= slow ? 8 : 1 + int'($urandom % 4);
		end else if (waitCnt == 1) begin
			// rejects until its budget runs out, then accepts
			txNackSeen <= (left != 8'h00);
			txCharEnd <= (left == 8'h00);
			left <= left - 8'h01;
			waitCnt <= 0;
		end else if (waitCnt > 1) begin
			waitCnt <= waitCnt - 1;
		end
	end
endmodule : udn_card_model
`default_nettype wire

// File: sim/test_udn_top.sv
// test_udn_top: random and corner checks of request routing and nacks.
// assumes udn_top with default parameters and the card model beside it.
`timescale 1ns/1ps
`default_nettype none
module test_udn_top;
	import udn_pkg::*;
	logic        ref_clk, nrst, ce, regWr, regRd;
	logic [7:0]  regAddr, regWdata, regRdata, nackCount;
	logic        txEmptyFlag, rxFullFlag, txCompleteFlag, txCompleteIrq;
	logic        txNackSeen, txCharEnd, nackSend, txRetransmit;
	logic        rxDiscard, txEnable, scMode, charGo, startTx, slow;
	udn_rx_evt_t rxEvt, charEvt;
	udn_req_t    txReq, rxReq;
	int          fails, check_count;

	udn_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .txEmptyFlag(txEmptyFlag),
		.rxFullFlag(rxFullFlag), .txCompleteFlag(txCompleteFlag),
		.rxEvt(rxEvt), .txNackSeen(txNackSeen), .txCharEnd(txCharEnd),
		.txReq(txReq), .rxReq(rxReq), .txCompleteIrq(txCompleteIrq),
		.nackSend(nackSend), .txRetransmit(txRetransmit),
		.rxDiscard(rxDiscard), .txEnable(txEnable), .scMode(scMode));
	udn_card_model u_card (.ref_clk(ref_clk), .nrst(nrst),
		.charGo(charGo), .charEvt(charEvt), .startTx(startTx),
		.nackCount(nackCount), .slow(slow),
		.txRetransmit(txRetransmit), .rxEvt(rxEvt),
		.txNackSeen(txNackSeen), .txCharEnd(txCharEnd));

	// 25 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test

	// register bus cycles; the trailing delay lets the write land
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask : rd

	// counts retransmit pulses until accept, a count, or the limit
	task automatic count_rt(input int lim, input int upto,
		output int cnt, output logic ended);
		cnt = 0;
		ended = 1'b0;
		for (int i = 0; i < lim && !ended && cnt < upto; i++) begin
			@(negedge ref_clk);
			cnt += int'(txRetransmit);
			ended = txCharEnd;
		end
	endtask : count_rt

	task automatic start_tx(input logic [7:0] nk, input logic sl);
		@(posedge ref_clk);
		startTx <= 1'b1;
		nackCount <= nk;
		slow <= sl;
		@(posedge ref_clk);
		startTx <= 1'b0;
	endtask : start_tx

	function automatic logic [7:0] req_exp(logic en, logic fl, logic sel);
		return (en & fl) ? (sel ? 8'h01 : 8'h02) : 8'h00;
	endfunction : req_exp

	function automatic logic [7:0] nack_exp(logic [7:0] c, udn_rx_evt_t e);
		return {7'h0, c[0] & ~c[1] & e.done & ((c[4] & e.overrun)
			| (c[3] & (e.parityErr | (c[2] & e.initInvalid))))};
	endfunction : nack_exp

	// main sequence
	initial begin
		logic [7:0]  d, ctl, drc, scc;
		udn_rx_evt_t ev;
		int          n;
		logic        ended;
		fails = 0;
		check_count = 0;
		{nrst, regWr, regRd, regAddr, regWdata, charGo, startTx} = '0;
		{txEmptyFlag, rxFullFlag, txCompleteFlag, slow, nackCount} = '0;
		charEvt = '0;
		ce = 1'b1;
		void'($urandom(32'ha914));
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		rd(OFS_DMARC, d);
		chk(d, 8'h00);
		rd(OFS_SCC, d);
		chk(d, 8'h00);
		rd(8'h55, d);
		chk(d, 8'h00);
		wr(OFS_DMARC, 8'hff);
		rd(OFS_DMARC, d);
		chk(d, 8'ha0);
		wr(OFS_SCC, 8'hfe);
		rd(OFS_SCC, d);
		chk(d, 8'h1e);
		chk({7'h0, scMode, rxDiscard}, 8'h00);
		// routing of empty and full onto interrupt or dma
		for (n = 0; n < 48; n++) begin
			ctl = 8'($urandom) & 8'he0;
			drc = 8'($urandom) & 8'ha0;
			if (ctl[7] && drc[7]) begin
				ctl[6] = 1'b0;
			end
			wr(OFS_DMARC, drc);
			wr(OFS_CTRL, ctl);
			@(posedge ref_clk);
			{txEmptyFlag, rxFullFlag, txCompleteFlag} <= 3'($urandom);
			@(negedge ref_clk);
			chk({6'h0, txReq}, req_exp(ctl[7], txEmptyFlag, drc[7]));
			chk({6'h0, rxReq}, req_exp(ctl[5], rxFullFlag, drc[5]));
			chk({7'h0, txCompleteIrq}, {7'h0, ctl[6] & txCompleteFlag});
		end
		// nack decisions, first two hand-picked
		for (n = 0; n < 64; n++) begin
			scc = 8'($urandom) & 8'h1f;
			ev = udn_rx_evt_t'({1'b1, 4'($urandom)});
			if (n < 2) begin
				scc = (n == 0) ? 8'h11 : 8'h13;
				ev = udn_rx_evt_t'(5'h14);
			end
			if (scc[2]) begin
				ev.parityErr = 1'b0;
				ev.overrun = 1'b0;
			end
			charEvt = ev;
			wr(OFS_SCC, 8'h00);
			wr(OFS_SCC, scc);
			chk({7'h0, rxDiscard}, {7'h0, scc[0] & ~scc[1] & scc[2]});
			@(posedge ref_clk);
			charGo <= 1'b1;
			@(posedge ref_clk);
			charGo <= 1'b0;
			@(negedge ref_clk);
			@(negedge ref_clk);
			chk({7'h0, nackSend}, nack_exp(scc, ev));
		end
		// endless retransmission, then a software abort
		wr(OFS_CTRL, 8'h08);
		chk({7'h0, txEnable}, 8'h01);
		wr(OFS_SCC, 8'h00);
		wr(OFS_SCC, 8'h09);
		start_tx(8'd20, 1'b0);
		count_rt(2000, 1000, n, ended);
		chk({7'h0, ended}, 8'h01);
		chk(8'(n), 8'd20);
		rd(OFS_RETRY, d);
		chk(d, 8'd20);
		start_tx(8'd5, 1'b1);
		count_rt(200, 2, n, ended);
		chk(8'(n), 8'd2);
		wr(OFS_CTRL, 8'h00);
		count_rt(40, 1000, n, ended);
		chk(8'(n), 8'd0);
		// tx done has been seen, so the transmitter may return; abort by mode
		txCompleteFlag <= 1'b1;
		wr(OFS_CTRL, 8'h08);
		start_tx(8'd5, 1'b1);
		count_rt(200, 1, n, ended);
		chk(8'(n), 8'd1);
		wr(OFS_SCC, 8'h08);
		count_rt(40, 1000, n, ended);
		chk(8'(n), 8'd0);
		rd(OFS_STAT, d);
		chk(d, {txEmptyFlag, 1'b1, rxFullFlag, 5'h00});
		stop_test();
	end
endmodule : test_udn_top
`default_nettype wire
